// file: hdl/iood_decode.sv
// Decode and execute of indexed literal offset byte and bit instructions.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Operand at most 5Fh indexes frame pointer.
// - Indexed form acts as access bit 0.
// - Destination bit picks accumulator or memory.
// - Add accumulator to frame byte, one cycle.
// - Add updates N, OV, C, DC, Z.
// - Add opcode 0010 01d0, low byte offset.
// - Bit set 1000 bbb0 sets bit b.
// - Set all ones 0110 1000 writes FFh.
// - Config bit clear disables extended mode.
// - Disabled: access bank or banked by pointer.
// - Frame pointer 00h restores access bank map.
module iood_decode import iood_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Instruction fetch.
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // Core state.
  input wire logic extended_set_config_bit,
  input wire logic [11:0] stack_frame_pointer,
  input wire logic [3:0] bank_select_pointer,
  input wire logic [7:0] accum_in,
  input wire logic [7:0] mem_rdata,
  // Data memory port.
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // Results.
  output logic accum_we,
  output logic [7:0] accum_wdata,
  output logic status_we,
  output logic [4:0] status_flags,
  output logic indexed_mode,
  output logic done
);

  // Memory data is read in the same cycle the registered address is presented, so one
  // instruction takes a decode cycle and an execute cycle; the core Q-phase
  // split maps onto these two clocks.
  iood_state_t state_q, state_d;
  logic [11:0] addr_q;
  logic [1:0] kind_q;
  logic dest_q;
  logic [2:0] bit_q;
  logic [11:0] mem_addr_q;
  logic mem_rd_q, mem_we_q, accum_we_q, status_we_q, indexed_q, done_q;
  logic [7:0] mem_wdata_q, accum_wdata_q;
  logic [4:0] flags_q;

  function automatic logic [4:0] add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [4:0] f;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    f = '0;
    f[IOOD_BIT_N] = s[7];
    f[IOOD_BIT_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    f[IOOD_BIT_Z] = (s[7:0] == 8'h00);
    f[IOOD_BIT_DC] = h[4];
    f[IOOD_BIT_C] = s[8];
    return f;
  endfunction

  function automatic logic low_ofs(input logic [7:0] f);
    return f <= IOOD_OFS_MAX;
  endfunction

  // Bit 8 is the access bit of add and bit set, so both of its values must decode.
  // add opcode match
  wire is_add = instr_word[15:10] == IOOD_OP_ADD;
  wire is_bset = instr_word[15:12] == IOOD_OP_BSET;
  wire is_set_all_ones_indexed = instr_word[15:8] == IOOD_OP_SET_ALL_ONES_INDEXED;
  wire [7:0] f_arg = instr_word[7:0];
  wire a_bit = is_set_all_ones_indexed ? 1'b0 : instr_word[IOOD_BIT_A];
  // indexed only at 5Fh or less
  wire use_index = extended_set_config_bit && !a_bit && low_ofs(f_arg);
  wire [11:0] idx_addr = 12'(stack_frame_pointer + {4'h0, f_arg});
  wire [11:0] acc_addr = low_ofs(f_arg) ? {4'h0, f_arg} : {IOOD_ACC_HI_BANK, f_arg};
  wire [11:0] ban_addr = {bank_select_pointer, f_arg};
  // pointer 00h yields legacy low half
  wire [11:0] eff_addr = use_index ? idx_addr : (a_bit ? ban_addr : acc_addr);
  wire known = is_add || is_bset || is_set_all_ones_indexed;
  wire start = (state_q == IOOD_ST_IDLE) && instr_valid && known;

  wire [7:0] sum = 8'(accum_in + mem_rdata);
  wire [7:0] bset_val = mem_rdata | (8'h01 << bit_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      IOOD_ST_IDLE: if (start) state_d = IOOD_ST_EXEC;
      IOOD_ST_EXEC: state_d = IOOD_ST_IDLE;
      default: state_d = IOOD_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= IOOD_ST_IDLE;
      addr_q <= '0;
      kind_q <= 2'h0;
      dest_q <= 1'b0;
      bit_q <= 3'h0;
      indexed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        addr_q <= eff_addr;
        kind_q <= is_add ? 2'h1 : (is_bset ? 2'h2 : 2'h3);
        dest_q <= instr_word[IOOD_BIT_D];
        bit_q <= instr_word[11:9];
        indexed_q <= use_index;
      end
    end
  end

  wire exec = state_q == IOOD_ST_EXEC;
  wire wr_mem = exec && (kind_q != 2'h1 || dest_q);
  wire wr_acc = exec && kind_q == 2'h1 && !dest_q;
  wire [7:0] wval = (kind_q == 2'h1) ? sum : (kind_q == 2'h2 ? bset_val : IOOD_ALL_ONES);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mem_addr_q <= '0;
      mem_rd_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
      accum_we_q <= 1'b0;
      accum_wdata_q <= 8'h00;
      status_we_q <= 1'b0;
      flags_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      mem_addr_q <= start ? eff_addr : addr_q;
      mem_rd_q <= start && !is_set_all_ones_indexed;
      mem_we_q <= wr_mem;
      mem_wdata_q <= wval;
      accum_we_q <= wr_acc;
      accum_wdata_q <= sum;
      status_we_q <= exec && kind_q == 2'h1;
      flags_q <= add_flags(accum_in, mem_rdata);
      done_q <= exec;
    end
  end

  assign mem_addr = mem_addr_q;
  assign mem_rd = mem_rd_q;
  assign mem_we = mem_we_q;
  assign mem_wdata = mem_wdata_q;
  assign accum_we = accum_we_q;
  assign accum_wdata = accum_wdata_q;
  assign status_we = status_we_q;
  assign status_flags = flags_q;
  assign indexed_mode = indexed_q;
  assign done = done_q;

  // Assertions.
  chk_index_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && use_index |=> mem_addr == $past(idx_addr)) else $error("indexed address wrong");
  chk_no_index: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && !extended_set_config_bit |=> !indexed_mode) else $error("indexed while disabled");
  chk_bank_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && !extended_set_config_bit && a_bit |=> mem_addr[11:8] == $past(bank_select_pointer))
    else $error("bank select wrong");
  chk_add_dest: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && is_add && !instr_word[IOOD_BIT_D] |=> ##1 accum_we && !mem_we) else $error("add dest wrong");
  chk_add_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && is_add |=> ##1 done ##1 !done) else $error("add not one execute");
  chk_flags_add: assert property (@(posedge ref_clk) disable iff (!rst_b)
    status_we |-> $past(kind_q) == 2'h1) else $error("flags by non add");
  chk_bset_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mem_we && $past(kind_q) == 2'h2 |-> mem_wdata[$past(bit_q)]) else $error("bit not set");
  chk_set_all_ones_indexed_ones: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && is_set_all_ones_indexed |=> ##1 mem_we && mem_wdata == IOOD_ALL_ONES && !status_we) else $error("set_all_ones_indexed wrong");
  chk_set_all_ones_indexed_noa: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && is_set_all_ones_indexed && extended_set_config_bit && f_arg <= IOOD_OFS_MAX |=> indexed_mode)
    else $error("set_all_ones_indexed not indexed");

  chk_add_sum: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    accum_we |-> accum_wdata == 8'($past(accum_in) + $past(mem_rdata)))
    else $error("add sum wrong");
  chk_flag_neg: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    status_we |-> status_flags[IOOD_BIT_N] == accum_wdata[7])
    else $error("negative flag wrong");
  chk_flag_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    status_we |-> status_flags[IOOD_BIT_Z] == (accum_wdata == 8'h00))
    else $error("zero flag wrong");
  chk_flag_ovf: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    status_we |-> status_flags[IOOD_BIT_OV] == ($past(accum_in[7]) == $past(mem_rdata[7]) &&
      accum_wdata[7] != $past(accum_in[7])))
    else $error("overflow flag wrong");

  chk_add_wdata: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    mem_we && $past(kind_q) == 2'h1 |-> mem_wdata == accum_wdata)
    else $error("add write back wrong");
  chk_we_excl: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !(mem_we && accum_we))
    else $error("two destinations written");
  chk_add_mem_dest: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && is_add && instr_word[IOOD_BIT_D] |=> ##1 mem_we && !accum_we)
    else $error("add memory dest wrong");

  chk_rd_pulse: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    mem_rd |=> !mem_rd)
    else $error("read not one cycle");
  chk_we_pulse: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    mem_we |=> !mem_we)
    else $error("write not one cycle");
  chk_done_pulse: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    done |=> !done)
    else $error("done not one cycle");
  chk_done_after_rd: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    mem_rd |=> done)
    else $error("done late after read");
  chk_exec_one: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    state_q == IOOD_ST_EXEC |=> state_q == IOOD_ST_IDLE)
    else $error("execute longer than one cycle");
  chk_state_onehot: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $onehot(state_q))
    else $error("state code illegal");
  chk_add_rd: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && is_add |=> mem_rd)
    else $error("add without read");

  chk_set_all_ones_indexed_no_rd: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && is_set_all_ones_indexed |=> !mem_rd)
    else $error("set_all_ones_indexed reads memory");
  chk_set_all_ones_indexed_no_acc: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && is_set_all_ones_indexed |=> ##1 !accum_we)
    else $error("set_all_ones_indexed writes accumulator");
  chk_bset_flags: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && is_bset |=> ##1 mem_we && !status_we && !accum_we)
    else $error("bit set side effect");
  chk_bset_keep: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    mem_we && $past(kind_q) == 2'h2 |-> mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_q))))
    else $error("bit set disturbs others");

  chk_idx_only_low: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && !low_ofs(f_arg) |=> !indexed_mode)
    else $error("indexed above split");
  chk_a_noidx: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && a_bit |=> !indexed_mode)
    else $error("indexed with access bit set");
  chk_acc_low: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && !extended_set_config_bit && !a_bit && low_ofs(f_arg) |=> mem_addr == {4'h0, $past(f_arg)})
    else $error("access bank low wrong");
  chk_acc_high: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && !a_bit && !low_ofs(f_arg) |=> mem_addr == {IOOD_ACC_HI_BANK, $past(f_arg)})
    else $error("access bank high wrong");
  chk_bank_low: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && a_bit |=> mem_addr[7:0] == $past(f_arg))
    else $error("banked offset wrong");
  chk_zero_ptr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start && use_index && stack_frame_pointer == 12'h000 |=> mem_addr == {4'h0, $past(f_arg)})
    else $error("zero pointer map wrong");

  chk_addr_stands: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !start |=> $stable(mem_addr))
    else $error("address moved while idle");
  chk_mode_stands: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !start |=> $stable(indexed_mode))
    else $error("mode moved while idle");

endmodule
`default_nettype wire

// file: hdl/iood_pkg.sv
// Constants for the indexed literal offset operand decoder.
package iood_pkg;
  localparam int IOOD_ADDR_W = 12;
  localparam logic [7:0] IOOD_OFS_MAX = 8'h5F;
  localparam logic [5:0] IOOD_OP_ADD = 6'h09;
  localparam logic [3:0] IOOD_OP_BSET = 4'h8;
  localparam logic [7:0] IOOD_OP_SET_ALL_ONES_INDEXED = 8'h68;
  localparam logic [7:0] IOOD_ALL_ONES = 8'hFF;
  localparam logic [3:0] IOOD_ACC_HI_BANK = 4'hF;
  localparam int IOOD_BIT_D = 9;
  localparam int IOOD_BIT_A = 8;
  localparam int IOOD_BIT_N = 4;
  localparam int IOOD_BIT_OV = 3;
  localparam int IOOD_BIT_Z = 2;
  localparam int IOOD_BIT_DC = 1;
  localparam int IOOD_BIT_C = 0;
  typedef enum logic [1:0] {
    IOOD_ST_IDLE = 2'b01,
    IOOD_ST_EXEC = 2'b10
  } iood_state_t;
endpackage

// file: tb/iood_mem_model.sv
// Data memory model on the decoder's memory port.
`timescale 1ns/1ps
`default_nettype none
module iood_mem_model (
  // Clock.
  input wire logic ref_clk,
  // Memory port.
  input wire logic [11:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  // Data follow the address at once, so they are settled whenever sampled.
  assign mem_rdata = mem[mem_addr];
  // A plain process, since the bench preloads this array directly.
  always @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// file: tb/indexed_offset_operand_decode_tb_top.sv
// Self-checking bench for the indexed offset decoder.
`timescale 1ns/1ps
`default_nettype none
module indexed_offset_operand_decode_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic iv = 1'b0;
  logic [15:0] iw = 16'h0000;
  logic cfg = 1'b0;
  logic [11:0] sfp = 12'h000;
  logic [3:0] bsp = 4'h0;
  logic [7:0] acc = 8'h00;
  logic [7:0] rdata, wdata, awdata;
  logic [11:0] addr;
  logic [4:0] flags;
  logic rd, we, awe, swe, im, done;
  int err_count = 0;
  int checks_done = 0;
  iood_decode i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(iv), .instr_word(iw),
    .extended_set_config_bit(cfg), .stack_frame_pointer(sfp), .bank_select_pointer(bsp), .accum_in(acc),
    .mem_rdata(rdata), .mem_addr(addr), .mem_rd(rd), .mem_we(we), .mem_wdata(wdata), .accum_we(awe),
    .accum_wdata(awdata), .status_we(swe), .status_flags(flags), .indexed_mode(im), .done(done));
  iood_mem_model i_mem (.ref_clk(ref_clk), .mem_addr(addr), .mem_we(we), .mem_wdata(wdata), .mem_rdata(rdata));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One instruction; then checks done, the mode flag and the effective address.
  task automatic op(input logic [15:0] w, input logic c, input logic [11:0] p, input logic [3:0] b,
                    input logic [7:0] a, input logic [15:0] exp);
    int n;
    logic rd_seen;
    @(posedge ref_clk);
    iv <= 1'b1;
    iw <= w;
    cfg <= c;
    sfp <= p;
    bsp <= b;
    acc <= a;
    @(posedge ref_clk);
    iv <= 1'b0;
    #1;
    rd_seen = rd;
    for (n = 0; n < 4 && done !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check({2'h0, done, im, addr}, exp);
    check({15'h0, rd_seen}, {15'h0, w[15:8] != 8'h68});
  endtask
  initial begin
    int i;
    for (i = 0; i < 4096; i++) begin
      i_mem.mem[i] = 8'h00;
    end
    repeat (5) @(posedge ref_clk);
    check({addr, rd, we, awe, done}, 16'h0000);
    rst_b <= 1'b1;
    i_mem.mem[12'hA2C] = 8'h20;
    i_mem.mem[12'h04F] = 8'h80;
    op(16'h242C, 1'b1, 12'hA00, 4'h0, 8'h17, 16'h3A2C);
    check({awe, swe, we, 5'h0, awdata}, 16'hC037);
    check({11'h0, flags}, 16'h0000);
    op(16'h265F, 1'b1, 12'hFF0, 4'h0, 8'h80, 16'h304F);
    check({awe, swe, we, 5'h0, wdata}, 16'h6000);
    check({11'h0, flags}, 16'h000D);
    for (i = 0; i < 8; i++) begin
      i_mem.mem[i] = 8'h00;
      op({4'h8, i[2:0], 1'b0, i[7:0]}, 1'b1, 12'h000, 4'h0, 8'h00, {8'h30, i[7:0]});
      check({we, swe, 6'h0, wdata}, {8'h80, 8'h01 << i});
    end
    op(16'h682C, 1'b1, 12'hA00, 4'h0, 8'h00, 16'h3A2C);
    check({we, swe, 6'h0, wdata}, 16'h80FF);
    op(16'h242C, 1'b0, 12'hA00, 4'h0, 8'h01, 16'h202C);
    op(16'h252C, 1'b0, 12'hA00, 4'h3, 8'h01, 16'h232C);
    op(16'h252C, 1'b1, 12'hA00, 4'h5, 8'h01, 16'h252C);
    op(16'h2460, 1'b1, 12'hA00, 4'h0, 8'h01, 16'h2F60);
    complete_run();
  end
  initial begin
    repeat (400) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
